// [core/hdtv_formatter.sv]
// Contract
// - Stream carries video, timing, line, check, blanking; check words are sent as blanking values
// - Video samples are 10-bit luma or chroma
// - Start and end codes use parallel format
// - Two line number words follow end code
// - Interleave order Cb, Y, Cr, Y
// - Word clock 74.25 or 72 MHz
// - Multiplexed stream carries two words per clock
// - Line is 2200 or 2304 words
// - Line blanking is 280 or 384 words
// - Ancillary region is 268 or 372 words
// - Multiplexed line, blanking, ancillary lengths double
// - Serial clock is twenty times word clock
// - Chroma in bits 19..10, luma 9..0
// - F, V, H form binary, F is MSB
// - Phase flag high with Cb, low Cr
module hdtv_formatter (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic core_ce,
    input wire logic sys_1250,
    input wire hdtv_fmt_pkg::par_word_t pix_in,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic link_clk,
    output hdtv_fmt_pkg::par_word_t par_out_ff,
    output hdtv_fmt_pkg::mux_pair_t mux_out_ff,
    output logic cb_phase_ff,
    output hdtv_fmt_pkg::fvh_t fvh_out_ff,
    output logic [10:0] line_num_ff,
    output logic underrun_ff
);
    // Link side synchronisers for reset, enable and system select
    logic rst_s1_ff, rst_s2_ff, ce_s1_ff, ce_s2_ff, sys_s1_ff, sys_s2_ff;
    logic sys_ff;
    logic [11:0] hcnt_ff;
    logic [10:0] line_ff;
    hdtv_fmt_pkg::par_word_t fifo_word;
    logic fifo_valid;
    hdtv_fmt_pkg::seg_t seg;
    hdtv_fmt_pkg::fvh_t cur_fvh;

    wire logic link_rst = rst_s2_ff;
    wire logic link_ce = ce_s2_ff;

    always_ff @(posedge link_clk) begin
        rst_s1_ff <= srst;
        rst_s2_ff <= rst_s1_ff;
        ce_s1_ff <= core_ce;
        ce_s2_ff <= ce_s1_ff;
        sys_s1_ff <= sys_1250;
        sys_s2_ff <= sys_s1_ff;
    end

    // Timing reference status word with protection bits
    function automatic logic [9:0] trs_word(input hdtv_fmt_pkg::fvh_t s);
        trs_word = {1'b1, s.f, s.v, s.h, s.v ^ s.h, s.f ^ s.h, s.f ^ s.v,
            s.f ^ s.v ^ s.h, 2'b00};
    endfunction

    // Field and vertical blanking flags of a line
    function automatic logic [1:0] fv_of(input logic [10:0] ln,
        input logic sys);
        logic [10:0] a1, e1, f2, a2, e2;
        a1 = sys ? hdtv_fmt_pkg::F1_ACT_1250 : hdtv_fmt_pkg::F1_ACT_1125;
        e1 = sys ? hdtv_fmt_pkg::F1_END_1250 : hdtv_fmt_pkg::F1_END_1125;
        f2 = sys ? hdtv_fmt_pkg::F2_START_1250 : hdtv_fmt_pkg::F2_START_1125;
        a2 = sys ? hdtv_fmt_pkg::F2_ACT_1250 : hdtv_fmt_pkg::F2_ACT_1125;
        e2 = sys ? hdtv_fmt_pkg::F2_END_1250 : hdtv_fmt_pkg::F2_END_1125;
        fv_of[1] = ln >= f2;
        fv_of[0] = !((ln >= a1 && ln <= e1) || (ln >= a2 && ln <= e2));
    endfunction

    // Buffer and clock crossing of incoming pixel pairs
    wire logic pop = link_ce & ~link_rst & (seg == hdtv_fmt_pkg::SEG_ACT)
        & ~cur_fvh.v;

    cdc_fifo #(
        .W(hdtv_fmt_pkg::PAR_W),
        .DEPTH(hdtv_fmt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .wr_clk(core_clk),
        .wr_rst(srst),
        .wr_ce(core_ce),
        .wr_data(pix_in),
        .wr_valid(pix_valid),
        .wr_ready(pix_ready),
        .rd_clk(link_clk),
        .rd_rst(link_rst),
        .rd_ce(link_ce),
        .rd_data(fifo_word),
        .rd_valid(fifo_valid),
        .rd_ready(pop)
    );

    // Per-system line figures
    wire logic [11:0] line_len = sys_ff ? hdtv_fmt_pkg::LINE_1250
        : hdtv_fmt_pkg::LINE_1125;
    wire logic [11:0] blank_len = sys_ff ? hdtv_fmt_pkg::BLANK_1250
        : hdtv_fmt_pkg::BLANK_1125;
    wire logic [11:0] anc_len = sys_ff ? hdtv_fmt_pkg::ANC_1250
        : hdtv_fmt_pkg::ANC_1125;
    wire logic [10:0] frame_len = sys_ff ? hdtv_fmt_pkg::LINES_1250
        : hdtv_fmt_pkg::LINES_1125;
    wire logic [11:0] start_pos = blank_len - hdtv_fmt_pkg::TRS_LEN;
    wire logic line_last = hdtv_fmt_pkg::LINE_1125 == line_len
        ? hcnt_ff == hdtv_fmt_pkg::LINE_1125 - 12'd1
        : hcnt_ff == hdtv_fmt_pkg::LINE_1250 - 12'd1;
    wire logic frame_last = line_ff == frame_len;

    // Segment decode from the word counter
    assign seg = hcnt_ff < hdtv_fmt_pkg::TRS_LEN ? hdtv_fmt_pkg::SEG_ENDC
        : hcnt_ff < hdtv_fmt_pkg::LN_END ? hdtv_fmt_pkg::SEG_LN
        : hcnt_ff < hdtv_fmt_pkg::EDC_END ? hdtv_fmt_pkg::SEG_EDC
        : hcnt_ff < start_pos ? hdtv_fmt_pkg::SEG_ANC
        : hcnt_ff < blank_len ? hdtv_fmt_pkg::SEG_STARTC
        : hdtv_fmt_pkg::SEG_ACT;

    // Current status flags and line number words
    wire logic [1:0] cur_fv = fv_of(line_ff, sys_ff);
    assign cur_fvh = {cur_fv, seg == hdtv_fmt_pkg::SEG_ENDC};
    wire logic [9:0] ln_lo = {~line_ff[6], line_ff[6:0], 2'b00};
    wire logic [9:0] ln_hi = {1'b1, 3'b000, line_ff[10:7], 2'b00};
    wire logic [9:0] trs_sel = hcnt_ff[1:0] == 2'd0 ? hdtv_fmt_pkg::TRS_ONES
        : hcnt_ff[1:0] == 2'd3 ? trs_word(cur_fvh)
        : hdtv_fmt_pkg::TRS_ZERO;
    wire logic [9:0] ln_sel = hcnt_ff[0] ? ln_hi : ln_lo;
    wire logic vid_ok = fifo_valid & ~cur_fvh.v;

    // Word selection, same content in both streams in timing codes and line number words
    hdtv_fmt_pkg::par_word_t nxt_word;
    always_comb begin
        unique case (seg)
            hdtv_fmt_pkg::SEG_ENDC, hdtv_fmt_pkg::SEG_STARTC: begin
                nxt_word = {trs_sel, trs_sel};
            end
            hdtv_fmt_pkg::SEG_LN: begin
                nxt_word = {ln_sel, ln_sel};
            end
            hdtv_fmt_pkg::SEG_EDC, hdtv_fmt_pkg::SEG_ANC: begin
                nxt_word = {hdtv_fmt_pkg::BLANK_CHROMA,
                    hdtv_fmt_pkg::BLANK_LUMA};
            end
            hdtv_fmt_pkg::SEG_ACT: begin
                nxt_word = vid_ok ? fifo_word
                    : {hdtv_fmt_pkg::BLANK_CHROMA,
                    hdtv_fmt_pkg::BLANK_LUMA};
            end
            default: begin
                nxt_word = '0;
            end
        endcase
    end

    // Word and line counters; system select taken at frame start
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            hcnt_ff <= '0;
            line_ff <= 11'd1;
            sys_ff <= 1'b0;
        end else if (link_ce) begin
            hcnt_ff <= line_last ? 12'd0 : hcnt_ff + 12'd1;
            if (line_last) begin
                line_ff <= frame_last ? 11'd1 : line_ff + 11'd1;
            end
            if (line_last && frame_last) begin
                sys_ff <= sys_s2_ff;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            par_out_ff <= '0;
            mux_out_ff <= '0;
            cb_phase_ff <= 1'b0;
            fvh_out_ff <= '0;
            line_num_ff <= 11'd1;
            underrun_ff <= 1'b0;
        end else if (link_ce) begin
            par_out_ff <= nxt_word;
            mux_out_ff <= {nxt_word.chroma, nxt_word.luma};
            cb_phase_ff <= hcnt_ff == blank_len ? 1'b1
                : ~cb_phase_ff;
            fvh_out_ff <= cur_fvh;
            line_num_ff <= line_ff;
            underrun_ff <= (seg == hdtv_fmt_pkg::SEG_ACT) & ~cur_fvh.v
                & ~fifo_valid;
        end
    end

    default clocking cb_link @(posedge link_clk); endclocking
    default disable iff (link_rst);

    sequence end_start_s;
        link_ce && hcnt_ff == 12'd0;
    endsequence
    sequence end_words_s;
        par_out_ff.luma == hdtv_fmt_pkg::TRS_ONES && link_ce
        ##1 par_out_ff.luma == hdtv_fmt_pkg::TRS_ZERO && link_ce
        ##1 par_out_ff.luma == hdtv_fmt_pkg::TRS_ZERO && link_ce
        ##1 par_out_ff.luma[9] && par_out_ff.luma[6];
    endsequence

    end_code_a: assert property (end_start_s |=> end_words_s)
        else $error("end code words wrong");
    line_words_a: assert property (link_ce && hcnt_ff == 12'd4 |=>
        par_out_ff.luma == {~line_num_ff[6], line_num_ff[6:0], 2'b00}
        && par_out_ff.chroma == par_out_ff.luma)
        else $error("line number word missing after end code");
    mux_order_a: assert property (link_ce |=>
        mux_out_ff.first == par_out_ff.chroma
        && mux_out_ff.second == par_out_ff.luma)
        else $error("multiplex order wrong");
    line_wrap_a: assert property (link_ce && hcnt_ff == line_len - 12'd1
        |=> hcnt_ff == 12'd0 && $changed(line_ff))
        else $error("line length wrong");
    line_bound_a: assert property (hcnt_ff < line_len)
        else $error("word counter beyond line");
    active_span_a: assert property ((seg == hdtv_fmt_pkg::SEG_ACT) ==
        (hcnt_ff >= blank_len))
        else $error("blanking length wrong");
    anc_span_a: assert property (seg == hdtv_fmt_pkg::SEG_ANC |->
        hcnt_ff >= hdtv_fmt_pkg::EDC_END
        && hcnt_ff < hdtv_fmt_pkg::EDC_END + anc_len)
        else $error("ancillary region wrong");
    fvh_order_a: assert property (link_ce && hcnt_ff == 12'd3 |=>
        par_out_ff.luma[8:6] == {fvh_out_ff.f, fvh_out_ff.v, 1'b1})
        else $error("status flag order wrong");
    cb_restart_a: assert property (link_ce && hcnt_ff == blank_len
        ##1 link_ce |-> cb_phase_ff ##1 !cb_phase_ff)
        else $error("colour phase not restarted");
    cb_alt_a: assert property (link_ce && hcnt_ff > blank_len
        |=> cb_phase_ff != $past(cb_phase_ff))
        else $error("colour phase not alternating");
endmodule

// [core/hdtv_fmt_pkg.sv]
package hdtv_fmt_pkg;
    // Word widths and buffer depth
    localparam int WORD_W = 10;
    localparam int PAR_W = 20;
    localparam int FIFO_DEPTH = 16;

    // Parallel word: chroma in bits 19..10, luma in bits 9..0
    typedef struct packed {
        logic [9:0] chroma;
        logic [9:0] luma;
    } par_word_t;

    // Multiplexed pair: first word then second word of one parallel clock
    typedef struct packed {
        logic [9:0] first;
        logic [9:0] second;
    } mux_pair_t;

    // Field, vertical blanking, line end; field is the MSB
    typedef struct packed {
        logic f;
        logic v;
        logic h;
    } fvh_t;

    // Line segments of one parallel stream
    typedef enum logic [2:0] {
        SEG_ENDC = 3'b000,
        SEG_LN  = 3'b001,
        SEG_EDC = 3'b010,
        SEG_ANC = 3'b011,
        SEG_STARTC = 3'b100,
        SEG_ACT = 3'b101
    } seg_t;

    // Clock figures per system
    localparam real PAR_MHZ_1125 = 74.25;
    localparam real PAR_MHZ_1250 = 72.0;
    localparam real PAR_PERIOD_NS_1125 = 1000.0 / PAR_MHZ_1125;
    localparam real PAR_PERIOD_NS_1250 = 1000.0 / PAR_MHZ_1250;
    localparam int SER_MULT = 20;
    localparam real SER_GHZ_1125 = PAR_MHZ_1125 * SER_MULT / 1000.0;
    localparam real SER_GHZ_1250 = PAR_MHZ_1250 * SER_MULT / 1000.0;
    localparam int MUX_PER_PAR = 2;

    // Line structure in parallel words, multiplexed figures in multiplexed words
    localparam logic [11:0] LINE_1125 = 12'd2200;
    localparam logic [11:0] LINE_1250 = 12'd2304;
    localparam logic [11:0] BLANK_1125 = 12'd280;
    localparam logic [11:0] BLANK_1250 = 12'd384;
    localparam logic [11:0] ANC_1125 = 12'd268;
    localparam logic [11:0] ANC_1250 = 12'd372;
    localparam logic [12:0] MUX_LINE_1125 = 13'd4400;
    localparam logic [12:0] MUX_LINE_1250 = 13'd4608;
    localparam logic [12:0] MUX_BLANK_1125 = 13'd560;
    localparam logic [12:0] MUX_BLANK_1250 = 13'd768;
    localparam logic [11:0] TRS_LEN = 12'd4;
    localparam logic [11:0] LN_END = 12'd6;
    localparam logic [11:0] EDC_END = 12'd8;

    // Frame structure in lines
    localparam logic [10:0] LINES_1125 = 11'd1125;
    localparam logic [10:0] LINES_1250 = 11'd1250;
    localparam logic [10:0] F1_ACT_1125 = 11'd41;
    localparam logic [10:0] F1_END_1125 = 11'd557;
    localparam logic [10:0] F2_START_1125 = 11'd564;
    localparam logic [10:0] F2_ACT_1125 = 11'd603;
    localparam logic [10:0] F2_END_1125 = 11'd1120;
    localparam logic [10:0] F1_ACT_1250 = 11'd45;
    localparam logic [10:0] F1_END_1250 = 11'd620;
    localparam logic [10:0] F2_START_1250 = 11'd626;
    localparam logic [10:0] F2_ACT_1250 = 11'd670;
    localparam logic [10:0] F2_END_1250 = 11'd1245;

    // Fixed word values
    localparam logic [9:0] TRS_ONES = 10'h3FF;
    localparam logic [9:0] TRS_ZERO = 10'h000;
    localparam logic [9:0] BLANK_LUMA = 10'h040;
    localparam logic [9:0] BLANK_CHROMA = 10'h200;
endpackage

// [core/cdc_fifo.sv]
module cdc_fifo #(
    parameter int W = 20,
    parameter int DEPTH = 16
) (
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic wr_ce,
    input wire logic [W-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic rd_clk,
    input wire logic rd_rst,
    input wire logic rd_ce,
    output logic [W-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
    logic [AW:0] rg_s1_ff, rg_s2_ff, wg_s1_ff, wg_s2_ff;
    logic full_ff, empty_ff;

    // Handshake decode
    wire logic push = wr_valid & ~full_ff & wr_ce;
    wire logic pop = rd_ready & ~empty_ff & rd_ce;
    wire logic [AW:0] nxt_wbin = wbin_ff + {{AW{1'b0}}, push};
    wire logic [AW:0] nxt_rbin = rbin_ff + {{AW{1'b0}}, pop};
    wire logic [AW:0] nxt_wgray = to_gray(nxt_wbin);
    wire logic [AW:0] nxt_rgray = to_gray(nxt_rbin);
    wire logic nxt_full = nxt_wgray == {~rg_s2_ff[AW:AW-1], rg_s2_ff[AW-2:0]};
    wire logic nxt_empty = nxt_rgray == wg_s2_ff;

    assign wr_ready = ~full_ff;
    assign rd_valid = ~empty_ff;
    assign rd_data = mem_ff[rbin_ff[AW-1:0]];

    // Write side: storage, pointer, full flag
    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem_ff[wbin_ff[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            wbin_ff <= '0;
            wgray_ff <= '0;
            rg_s1_ff <= '0;
            rg_s2_ff <= '0;
            full_ff <= 1'b0;
        end else if (wr_ce) begin
            wbin_ff <= nxt_wbin;
            wgray_ff <= nxt_wgray;
            rg_s1_ff <= rgray_ff;
            rg_s2_ff <= rg_s1_ff;
            full_ff <= nxt_full;
        end
    end

    // Read side: pointer, empty flag
    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            rbin_ff <= '0;
            rgray_ff <= '0;
            wg_s1_ff <= '0;
            wg_s2_ff <= '0;
            empty_ff <= 1'b1;
        end else if (rd_ce) begin
            rbin_ff <= nxt_rbin;
            rgray_ff <= nxt_rgray;
            wg_s1_ff <= wgray_ff;
            wg_s2_ff <= wg_s1_ff;
            empty_ff <= nxt_empty;
        end
    end

    no_push_full_a: assert property (@(posedge wr_clk) disable iff (wr_rst)
        full_ff |-> !push)
        else $error("fifo accepted a word while full");
    no_pop_empty_a: assert property (@(posedge rd_clk) disable iff (rd_rst)
        (empty_ff && rd_ce) |=> $stable(rbin_ff))
        else $error("fifo read pointer moved while empty");
endmodule

// [dv/hdtv_sink.sv]
module hdtv_sink (
    input wire logic link_clk,
    input wire logic srst,
    input wire hdtv_fmt_pkg::par_word_t par_out_ff,
    input wire hdtv_fmt_pkg::mux_pair_t mux_out_ff,
    input wire logic cb_phase_ff,
    input wire hdtv_fmt_pkg::fvh_t fvh_out_ff,
    input wire logic underrun_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] w;
    logic [19:0] h0, h1, h2;
    logic [19:0] ln_lo, ln_hi;
    logic [9:0] end_xyz, start_xyz;
    logic [2:0] end_fvh;
    logic active;
    logic trs;
    int idx, line_len, end_cnt, start_cnt, start_pos, act_n, mux_bad;
    logic [19:0] act [18];
    logic cb [18];
    logic und [18];

    // Timing code seen when both streams agree after 3FF,000,000
    assign w = par_out_ff;
    assign trs = h2 == 20'hFFFFF && h1 == 20'h0 && h0 == 20'h0
        && w[19:10] == w[9:0];

    // Destination samples every word on the link clock edge
    always @(posedge link_clk) begin
        if (srst) begin
            {h0, h1, h2} <= '0;
            {idx, end_cnt, start_cnt, act_n, mux_bad} <= '0;
            active <= 1'b0;
        end else begin
            h2 <= h1;
            h1 <= h0;
            h0 <= w;
            idx <= idx + 1;
            if ({mux_out_ff.first, mux_out_ff.second} !== w) begin
                mux_bad <= mux_bad + 1;
            end
            if (idx == 4) ln_lo <= w;
            if (idx == 5) ln_hi <= w;
            if (trs && w[6]) begin
                line_len <= idx - 3;
                idx <= 4;
                end_cnt <= end_cnt + 1;
                end_xyz <= w[9:0];
                end_fvh <= fvh_out_ff;
                active <= 1'b0;
            end else if (trs) begin
                start_pos <= idx - 3;
                start_cnt <= start_cnt + 1;
                start_xyz <= w[9:0];
                active <= 1'b1;
                act_n <= 0;
            end else if (active && act_n < 18) begin
                act[act_n] <= w;
                cb[act_n] <= cb_phase_ff;
                und[act_n] <= underrun_ff;
                act_n <= act_n + 1;
            end
        end
    end
endmodule

// [dv/hdtv_formatter_tb.sv]
module hdtv_formatter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic core_ce = 1'b1;
    logic sys_1250 = 1'b0;
    logic pix_valid = 1'b0;
    hdtv_fmt_pkg::par_word_t pix_in = '0;
    logic pix_ready;
    hdtv_fmt_pkg::par_word_t par_out;
    hdtv_fmt_pkg::mux_pair_t mux_out;
    logic cb_phase;
    hdtv_fmt_pkg::fvh_t fvh;
    logic [10:0] line_num;
    logic underrun;
    int err_total = 0;
    int compares = 0;

    // Core and link clocks, unrelated periods
    always #10 core_clk = ~core_clk;
    always #7.5 link_clk = ~link_clk;

    hdtv_formatter dut (
        .core_clk(core_clk), .srst(srst), .core_ce(core_ce),
        .sys_1250(sys_1250), .pix_in(pix_in), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .link_clk(link_clk), .par_out_ff(par_out),
        .mux_out_ff(mux_out), .cb_phase_ff(cb_phase), .fvh_out_ff(fvh),
        .line_num_ff(line_num), .underrun_ff(underrun)
    );

    hdtv_sink sink (
        .link_clk(link_clk), .srst(srst), .par_out_ff(par_out),
        .mux_out_ff(mux_out), .cb_phase_ff(cb_phase), .fvh_out_ff(fvh),
        .underrun_ff(underrun)
    );

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Reset values while held, then release after 16 cycles
    task automatic test_reset;
        repeat (12) @(negedge core_clk);
        check(20'(pix_ready), 20'h1);
        check(20'(line_num), 20'h1);
        check(par_out, 20'h0);
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
    endtask

    // Timing codes, line number words and blanking span of line 1
    task automatic test_first_line;
        wait (sink.start_cnt == 1);
        @(negedge link_clk);
        check(20'(sink.end_xyz), 20'h2D8);
        check(20'(sink.end_fvh), 20'h3);
        check(sink.ln_lo, {10'h204, 10'h204});
        check(sink.ln_hi, {10'h200, 10'h200});
        check(20'(sink.start_pos), 20'(hdtv_fmt_pkg::BLANK_1125 - 4));
        check(20'(sink.start_pos - 8), 20'(hdtv_fmt_pkg::ANC_1125));
        check(20'(sink.start_xyz), 20'h2AC);
    endtask

    // Line length holds although system select changes mid-frame
    task automatic test_line_len;
        @(negedge core_clk);
        sys_1250 = 1'b1;
        wait (sink.start_cnt == 3);
        @(negedge link_clk);
        check(20'(sink.line_len), 20'(hdtv_fmt_pkg::LINE_1125));
        check(sink.ln_lo, {10'h20C, 10'h20C});
        @(negedge core_clk);
        sys_1250 = 1'b0;
    endtask

    // Fill the buffer in blanking, then see it drain in line 41
    task automatic test_active;
        int n;
        n = 0;
        wait (line_num == 11'd40);
        @(negedge core_clk);
        while (pix_ready === 1'b1 && n < 40) begin
            pix_in.chroma = 10'h100 + 10'(n);
            pix_in.luma = 10'h080 + 10'(n);
            pix_valid = 1'b1;
            @(negedge core_clk);
            n++;
        end
        pix_valid = 1'b0;
        check(20'(n), 20'(hdtv_fmt_pkg::FIFO_DEPTH));
        wait (sink.start_cnt == 41 && sink.act_n == 18);
        @(negedge link_clk);
        check(20'(sink.end_xyz), 20'h274);
        check(20'(sink.end_fvh), 20'h1);
        for (int i = 0; i < 16; i++) begin
            check(sink.act[i], {10'h100 + 10'(i), 10'h080 + 10'(i)});
            check(20'(sink.cb[i]), 20'(i % 2 == 0));
            check(20'(sink.und[i]), 20'h0);
        end
        check(sink.act[16], {10'h200, 10'h040});
        check(20'(sink.und[16]), 20'h1);
        @(negedge core_clk);
        check(20'(pix_ready), 20'h1);
        check(20'(sink.mux_bad), 20'h0);
    endtask

    initial begin
        test_reset();
        test_first_line();
        test_line_len();
        test_active();
        finish_test();
    end

    // Watchdog sized for 41 lines of link traffic plus margin
    initial begin
        #1500000;
        err_total++;
        $display("watchdog expired at %0t", $time);
        finish_test();
    end
endmodule
